/* File: core/spfm_pin_mux.sv */
// top of the shared pin function mux: control bus and general pin routing,
// the setup registers that steer it, and the second timer expiry pulse.
// assumes pads resolve level from out/oe outside; pins sync to mclk.
//
// Overview of operation
// - timer_b_expired pulses one cycle on count match
// - inputs pull up; link, trst, tms pull down
// - control bus routed by configured mode
// - lines 7..0: address, converter address, aux port
// - RAM mode lines 15..8 high address
// - RAM mode lines 18..21 four chip selects
// - RAM lines 22..24 out, 25..27 in
// - converter lines 8..13 out, 23 trigger in
// - queue lines 18..21 direction follows mode
// - queue flags: 14..17 out, 24..27 in
// - general pins follow io_port_a unless rerouted
// - uart_a_control bit7 routes pins 0,1 handshake
// - interface_config bit6 routes pins 2,3 interrupts
// - interface_config bit7 routes pins 4,5 uart_b
// - uart_b_control bit7 routes pins 6,7 handshake
// - passive queue mode disables converter lines
`timescale 1ns/1ps
`default_nettype none

module spfm_pin_mux
    import spfm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    // register port from the device controller
    input wire logic [7:0] reg_addr,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // control bus pads
    input wire logic [27:0] shared_control_bus_in,
    output logic [27:0] shared_control_bus_out,
    output logic [27:0] shared_control_bus_oe,
    // general pins pads
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe,
    // function units
    input wire spfm_mem_out_s mem_o,
    output spfm_mem_in_s mem_i,
    input wire spfm_conv_out_s conv_o,
    output logic converter_trigger,
    input wire spfm_queue_out_s queue_o,
    output spfm_queue_in_s queue_i,
    // uart and interrupt alternates
    input wire logic uart_a_request_to_send_n,
    output logic uart_a_clear_to_send_n,
    output logic external_irq0_n,
    output logic external_irq1_n,
    input wire logic uart_b_tx,
    output logic uart_b_rx,
    input wire logic uart_b_request_to_send_n,
    output logic uart_b_clear_to_send_n,
    // second timer
    input wire logic [SPFM_TMR_W-1:0] timer_b_count,
    input wire logic [SPFM_TMR_W-1:0] timer_b_period,
    output logic timer_b_expired,
    // pad pull enables
    output logic [27:0] bus_pull_up,
    output logic [7:0] gpio_pull_up,
    output logic [1:0] link_pull_down,
    output logic [1:0] jtag_pull_down
);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // address match helper used by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // setup registers
    logic [7:0] iface_cfg_q, iface_cfg_d;
    logic [7:0] uart_a_ctrl_q, uart_a_ctrl_d;
    logic [7:0] port_a_data_q, port_a_data_d;
    logic [7:0] port_a_dir_q, port_a_dir_d;
    logic [7:0] aux_data_q, aux_data_d;
    logic [7:0] aux_dir_q, aux_dir_d;
    logic [7:0] uart_b_ctrl_q, uart_b_ctrl_d; // second uart setup
    logic [7:0] rdata_q, rdata_d;
    spfm_mode_e mode; // decoded bus mode

    // pin side registers
    logic [27:0] bus_out_q, bus_out_d, bus_oe_q, bus_oe_d;
    logic [7:0] gp_out_q, gp_out_d, gp_oe_q, gp_oe_d;
    spfm_mem_in_s mem_i_q, mem_i_d;
    spfm_queue_in_s queue_i_q, queue_i_d;
    logic trig_q, trig_d;
    logic [4:0] alt_in_q, alt_in_d; // cts_a, irq0, irq1, rx_b, cts_b

    // general pin alternates
    logic [7:0] alt_sel; // per pin: routed to alternate
    logic [7:0] alt_val; // per pin: alternate output level

    // timer
    logic match, match_q, match_d, exp_q, exp_d;

    // register writes and readback
    always_comb begin
        iface_cfg_d = iface_cfg_q;
        uart_a_ctrl_d = uart_a_ctrl_q;
        port_a_data_d = port_a_data_q;
        port_a_dir_d = port_a_dir_q;
        aux_data_d = aux_data_q;
        aux_dir_d = aux_dir_q;
        uart_b_ctrl_d = uart_b_ctrl_q;
        if (reg_we) begin
            if (hit(reg_addr, SPFM_OFF_IFACE_CFG)) iface_cfg_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_UART_A_CTRL)) uart_a_ctrl_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_PORT_A_DATA)) port_a_data_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_PORT_A_DIR)) port_a_dir_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_AUX_DATA)) aux_data_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_AUX_DIR)) aux_dir_d = reg_wdata;
            if (hit(reg_addr, SPFM_OFF_UART_B_CTRL)) uart_b_ctrl_d = reg_wdata;
        end
        // readback: data registers show live pad levels
        if (hit(reg_addr, SPFM_OFF_IFACE_CFG)) begin
            rdata_d = iface_cfg_q;
        end else if (hit(reg_addr, SPFM_OFF_UART_A_CTRL)) begin
            rdata_d = uart_a_ctrl_q;
        end else if (hit(reg_addr, SPFM_OFF_PORT_A_DATA)) begin
            rdata_d = gpio_in;
        end else if (hit(reg_addr, SPFM_OFF_PORT_A_DIR)) begin
            rdata_d = port_a_dir_q;
        end else if (hit(reg_addr, SPFM_OFF_AUX_DATA)) begin
            rdata_d = shared_control_bus_in[7:0];
        end else if (hit(reg_addr, SPFM_OFF_AUX_DIR)) begin
            rdata_d = aux_dir_q;
        end else if (hit(reg_addr, SPFM_OFF_UART_B_CTRL)) begin
            rdata_d = uart_b_ctrl_q;
        end else begin
            rdata_d = SPFM_UNMAPPED_READ;
        end
    end

    // setup register flops, cleared by reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            iface_cfg_q <= SPFM_RST_REG;
            uart_a_ctrl_q <= SPFM_RST_REG;
            port_a_data_q <= SPFM_RST_REG;
            port_a_dir_q <= SPFM_RST_REG;
            aux_data_q <= SPFM_RST_REG;
            aux_dir_q <= SPFM_RST_REG;
            uart_b_ctrl_q <= SPFM_RST_REG;
            rdata_q <= SPFM_RST_REG;
        end else begin
            iface_cfg_q <= iface_cfg_d;
            uart_a_ctrl_q <= uart_a_ctrl_d;
            port_a_data_q <= port_a_data_d;
            port_a_dir_q <= port_a_dir_d;
            aux_data_q <= aux_data_d;
            aux_dir_q <= aux_dir_d;
            uart_b_ctrl_q <= uart_b_ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign mode = spfm_mode_e'(iface_cfg_q[SPFM_MODE_LSB +: 2]);

    // control bus routing by mode
    always_comb begin
        bus_out_d = '0;
        bus_oe_d = '0;
        mem_i_d = '{bus_request_n: 1'b1, start_tx: 1'b0, start_rx: 1'b0};
        queue_i_d = '{tx_eop_a: 1'b0, tx_eop_b: 1'b0, rx_eop_ack: 1'b0,
                      tx_parity: 1'b0, read_n: 1'b1, write_n: 1'b1,
                      empty_n: 1'b1, full_n: 1'b1};
        trig_d = 1'b0;
        case (mode)
            SPFM_MODE_RAM: begin
                bus_out_d[15:0] = mem_o.addr;
                bus_oe_d[15:0] = 16'hffff;
                bus_out_d[SPFM_L_MEM_WR] = mem_o.write_n;
                bus_out_d[SPFM_L_MEM_RD] = mem_o.read_n;
                bus_oe_d[SPFM_L_MEM_RD:SPFM_L_MEM_WR] = 2'h3;
                bus_out_d[SPFM_L_SEL +: 4] = mem_o.select_n;
                bus_oe_d[SPFM_L_SEL +: 4] = 4'hf;
                bus_out_d[SPFM_L_TEST] = mem_o.test;
                bus_out_d[SPFM_L_TXRDY] = mem_o.tx_ready;
                bus_out_d[SPFM_L_RXRDY] = mem_o.rx_ready;
                bus_oe_d[SPFM_L_RXRDY:SPFM_L_TEST] = 3'h7;
                // lines 25..27 stay inputs
                mem_i_d.bus_request_n = shared_control_bus_in[SPFM_L_BREQ];
                mem_i_d.start_tx = shared_control_bus_in[SPFM_L_STX];
                mem_i_d.start_rx = shared_control_bus_in[SPFM_L_SRX];
            end
            SPFM_MODE_QACT, SPFM_MODE_QPAS: begin
                // converter lines exist only in active queue mode
                if (mode == SPFM_MODE_QACT) begin
                    bus_out_d[7:0] = conv_o.adc_addr;
                    bus_out_d[SPFM_L_ADC_CS] = conv_o.adc_select_n;
                    bus_out_d[SPFM_L_ADC_RC] = conv_o.adc_read_convert;
                    bus_out_d[SPFM_L_DAC_WR] = conv_o.dac_write_n;
                    bus_out_d[SPFM_L_DAC_A +: 3] = conv_o.output_conv_addr;
                    bus_oe_d[13:0] = 14'h3fff;
                    trig_d = shared_control_bus_in[SPFM_L_TRIG];
                end
                // queue flags out
                bus_out_d[SPFM_L_Q_EACK] = queue_o.tx_eop_ack;
                bus_out_d[SPFM_L_Q_RPAR] = queue_o.rx_parity;
                bus_out_d[SPFM_L_Q_REOP] = queue_o.rx_eop_a;
                bus_out_d[SPFM_L_Q_REOP+1] = queue_o.rx_eop_b;
                bus_oe_d[SPFM_L_Q_REOP+1:SPFM_L_Q_EACK] = 4'hf;
                // queue flags in
                queue_i_d.tx_eop_a = shared_control_bus_in[SPFM_L_Q_TEOP];
                queue_i_d.tx_eop_b = shared_control_bus_in[SPFM_L_Q_TEOP+1];
                queue_i_d.rx_eop_ack = shared_control_bus_in[SPFM_L_Q_REACK];
                queue_i_d.tx_parity = shared_control_bus_in[SPFM_L_Q_TPAR];
                bus_out_d[SPFM_L_Q_RD] = queue_o.read_n;
                bus_out_d[SPFM_L_Q_WR] = queue_o.write_n;
                bus_out_d[SPFM_L_Q_EMP] = queue_o.empty_n;
                bus_out_d[SPFM_L_Q_FUL] = queue_o.full_n;
                if (mode == SPFM_MODE_QACT) begin
                    // device strobes, far queue reports its flags
                    bus_oe_d[SPFM_L_Q_WR:SPFM_L_Q_RD] = 2'h3;
                    queue_i_d.empty_n = shared_control_bus_in[SPFM_L_Q_EMP];
                    queue_i_d.full_n = shared_control_bus_in[SPFM_L_Q_FUL];
                end else begin
                    // far side strobes, device reports its flags
                    bus_oe_d[SPFM_L_Q_FUL:SPFM_L_Q_EMP] = 2'h3;
                    queue_i_d.read_n = shared_control_bus_in[SPFM_L_Q_RD];
                    queue_i_d.write_n = shared_control_bus_in[SPFM_L_Q_WR];
                end
            end
            SPFM_MODE_GPIO: begin
                bus_out_d[7:0] = aux_data_q;
                bus_oe_d[7:0] = aux_dir_q;
            end
            default: begin
                bus_oe_d = '0;
            end
        endcase
    end

    // general pin alternates, in pin order 7..0
    assign alt_sel = {{2{uart_b_ctrl_q[SPFM_HS_SEL_BIT]}},
                      {2{iface_cfg_q[SPFM_UARTB_SEL_BIT]}},
                      {2{iface_cfg_q[SPFM_IRQ_SEL_BIT]}},
                      {2{uart_a_ctrl_q[SPFM_HS_SEL_BIT]}}};
    assign alt_val = {1'b1, uart_b_request_to_send_n, 1'b1, uart_b_tx,
                      2'b11, 1'b1, uart_a_request_to_send_n};

    // per pin: port register or alternate
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            if (alt_sel[i]) begin
                gp_out_d[i] = alt_val[i];
                gp_oe_d[i] = SPFM_ALT_DRIVE[i];
            end else begin
                gp_out_d[i] = port_a_data_q[i];
                gp_oe_d[i] = port_a_dir_q[i];
            end
        end
    end

    // alternate inputs idle high when not routed
    always_comb begin
        alt_in_d[0] = alt_sel[1] ? gpio_in[1] : 1'b1;
        alt_in_d[1] = alt_sel[2] ? gpio_in[2] : 1'b1;
        alt_in_d[2] = alt_sel[3] ? gpio_in[3] : 1'b1;
        alt_in_d[3] = alt_sel[5] ? gpio_in[5] : 1'b1;
        alt_in_d[4] = alt_sel[7] ? gpio_in[7] : 1'b1;
    end

    // pin side flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bus_out_q <= '0;
            bus_oe_q <= '0;
            gp_out_q <= '0;
            gp_oe_q <= '0;
            mem_i_q <= '{bus_request_n: 1'b1, start_tx: 1'b0, start_rx: 1'b0};
            queue_i_q <= '{tx_eop_a: 1'b0, tx_eop_b: 1'b0, rx_eop_ack: 1'b0,
                           tx_parity: 1'b0, read_n: 1'b1, write_n: 1'b1,
                           empty_n: 1'b1, full_n: 1'b1};
            trig_q <= 1'b0;
            alt_in_q <= 5'h1f;
        end else begin
            bus_out_q <= bus_out_d;
            bus_oe_q <= bus_oe_d;
            gp_out_q <= gp_out_d;
            gp_oe_q <= gp_oe_d;
            mem_i_q <= mem_i_d;
            queue_i_q <= queue_i_d;
            trig_q <= trig_d;
            alt_in_q <= alt_in_d;
        end
    end

    // timer expiry: one pulse on entering a match
    assign match = (timer_b_count == timer_b_period);
    always_comb begin
        match_d = match;
        exp_d = match & ~match_q;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            match_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            match_q <= match_d;
            exp_q <= exp_d;
        end
    end

    // outputs
    assign reg_rdata = rdata_q;
    assign shared_control_bus_out = bus_out_q;
    assign shared_control_bus_oe = bus_oe_q;
    assign gpio_out = gp_out_q;
    assign gpio_oe = gp_oe_q;
    assign mem_i = mem_i_q;
    assign queue_i = queue_i_q;
    assign converter_trigger = trig_q;
    assign uart_a_clear_to_send_n = alt_in_q[0];
    assign external_irq0_n = alt_in_q[1];
    assign external_irq1_n = alt_in_q[2];
    assign uart_b_rx = alt_in_q[3];
    assign uart_b_clear_to_send_n = alt_in_q[4];
    assign timer_b_expired = exp_q;
    assign bus_pull_up = SPFM_BUS_PULLUP;
    assign gpio_pull_up = SPFM_GPIO_PULLUP;
    assign link_pull_down = SPFM_LINK_PULLDOWN;
    assign jtag_pull_down = SPFM_JTAG_PULLDOWN;

    // checks
    AST_TMR_ONE: assert property (timer_b_expired |=> !timer_b_expired)
        else $error("timer expiry longer than one cycle");
    AST_TMR_CAUSE: assert property (match && !match_q |=> timer_b_expired)
        else $error("timer expiry missing after match");
    AST_RAM_ADDR: assert property ((mode == SPFM_MODE_RAM) |=>
        shared_control_bus_out[15:0] == $past(mem_o.addr)
        && shared_control_bus_oe[15:0] == 16'hffff)
        else $error("ram address not on bus");
    AST_RAM_SEL: assert property ((mode == SPFM_MODE_RAM) |=>
        shared_control_bus_out[21:16] ==
        $past({mem_o.select_n, mem_o.read_n, mem_o.write_n}))
        else $error("ram strobes or selects wrong");
    AST_RAM_INS: assert property ((mode == SPFM_MODE_RAM) |=>
        shared_control_bus_oe[27:22] == 6'h07)
        else $error("ram input lines driven");
    AST_AUX: assert property ((mode == SPFM_MODE_GPIO) |=>
        shared_control_bus_oe[7:0] == $past(aux_dir_q)
        && shared_control_bus_oe[27:8] == 20'h00000)
        else $error("aux port not on low lines");
    AST_QDIR: assert property ((mode == SPFM_MODE_QACT) |=>
        shared_control_bus_oe[21:18] == 4'h3 ##1 1'b1)
        else $error("active queue direction wrong");
    AST_PASSIVE: assert property ((mode == SPFM_MODE_QPAS) |=>
        shared_control_bus_oe[21:8] == 14'h33c0 && !converter_trigger)
        else $error("converter lines live in passive mode");
    AST_GPIO_PORT: assert property (!alt_sel[0] |=>
        gpio_out[0] == $past(port_a_data_q[0]))
        else $error("pin 0 not from port register");
    AST_UART_A: assert property (alt_sel[0] |=>
        gpio_out[0] == $past(uart_a_request_to_send_n) && gpio_oe[0])
        else $error("pin 0 not handshake");
    AST_UART_B: assert property (alt_sel[4] |=>
        gpio_out[4] == $past(uart_b_tx) && uart_b_rx == $past(gpio_in[5]))
        else $error("pins 4,5 not second uart");
    AST_RESET: assert property (@(posedge mclk) disable iff (1'b0)
        sys_rst |=> iface_cfg_q == SPFM_RST_REG && gpio_oe == 8'h00)
        else $error("selection not cleared by reset");

endmodule : spfm_pin_mux

`default_nettype wire

/* File: core/spfm_pkg.sv */
// package for the shared pin function mux: register map, field positions,
// control bus line positions, pull defaults and the carrier structs.
// assumes an 8-bit internal register port driven by the device controller.
package spfm_pkg;

    // register offsets (8-bit registers, byte addressed)
    localparam logic [7:0] SPFM_OFF_IFACE_CFG = 8'h01;
    localparam logic [7:0] SPFM_OFF_UART_A_CTRL = 8'h59;
    localparam logic [7:0] SPFM_OFF_UART_B_CTRL = 8'h72;
    localparam logic [7:0] SPFM_OFF_PORT_A_DATA = 8'h63;
    localparam logic [7:0] SPFM_OFF_PORT_A_DIR = 8'h64;
    localparam logic [7:0] SPFM_OFF_AUX_DATA = 8'h65;
    localparam logic [7:0] SPFM_OFF_AUX_DIR = 8'h66;
    localparam logic [7:0] SPFM_RST_REG = 8'h00;
    localparam logic [7:0] SPFM_UNMAPPED_READ = 8'h00;

    // field positions
    localparam int SPFM_MODE_LSB = 0;
    localparam int SPFM_IRQ_SEL_BIT = 6;
    localparam int SPFM_UARTB_SEL_BIT = 7;
    localparam int SPFM_HS_SEL_BIT = 7;

    // timer width
    localparam int SPFM_TMR_W = 32;

    // control bus line positions
    localparam int SPFM_L_ADDR_HI = 8;
    localparam int SPFM_L_MEM_WR = 16;
    localparam int SPFM_L_MEM_RD = 17;
    localparam int SPFM_L_SEL = 18;
    localparam int SPFM_L_TEST = 22;
    localparam int SPFM_L_TXRDY = 23;
    localparam int SPFM_L_RXRDY = 24;
    localparam int SPFM_L_BREQ = 25;
    localparam int SPFM_L_STX = 26;
    localparam int SPFM_L_SRX = 27;
    localparam int SPFM_L_ADC_CS = 8;
    localparam int SPFM_L_ADC_RC = 9;
    localparam int SPFM_L_DAC_WR = 10;
    localparam int SPFM_L_DAC_A = 11;
    localparam int SPFM_L_Q_EACK = 14;
    localparam int SPFM_L_Q_RPAR = 15;
    localparam int SPFM_L_Q_REOP = 16;
    localparam int SPFM_L_Q_RD = 18;
    localparam int SPFM_L_Q_WR = 19;
    localparam int SPFM_L_Q_EMP = 20;
    localparam int SPFM_L_Q_FUL = 21;
    localparam int SPFM_L_TRIG = 23;
    localparam int SPFM_L_Q_TEOP = 24;
    localparam int SPFM_L_Q_REACK = 26;
    localparam int SPFM_L_Q_TPAR = 27;

    // general pin pin roles: which alternates the device drives
    localparam logic [7:0] SPFM_ALT_DRIVE = 8'h51;

    // pad pull defaults, one bit per pad
    localparam logic [27:0] SPFM_BUS_PULLUP = 28'hfffffff;
    localparam logic [7:0] SPFM_GPIO_PULLUP = 8'hff;
    localparam logic [1:0] SPFM_LINK_PULLDOWN = 2'h3;
    localparam logic [1:0] SPFM_JTAG_PULLDOWN = 2'h3;

    // control bus mode
    typedef enum logic [1:0] {
        SPFM_MODE_GPIO = 2'b00,
        SPFM_MODE_RAM = 2'b01,
        SPFM_MODE_QACT = 2'b10,
        SPFM_MODE_QPAS = 2'b11
    } spfm_mode_e;

    // memory unit to pins
    typedef struct packed {
        logic [15:0] addr;
        logic write_n;
        logic read_n;
        logic [3:0] select_n;
        logic test;
        logic tx_ready;
        logic rx_ready;
    } spfm_mem_out_s;

    // pins to memory unit
    typedef struct packed {
        logic bus_request_n;
        logic start_tx;
        logic start_rx;
    } spfm_mem_in_s;

    // converter unit to pins
    typedef struct packed {
        logic [7:0] adc_addr;
        logic adc_select_n;
        logic adc_read_convert;
        logic dac_write_n;
        logic [2:0] output_conv_addr;
    } spfm_conv_out_s;

    // queue unit to pins
    typedef struct packed {
        logic tx_eop_ack;
        logic rx_parity;
        logic rx_eop_a;
        logic rx_eop_b;
        logic read_n;
        logic write_n;
        logic empty_n;
        logic full_n;
    } spfm_queue_out_s;

    // pins to queue unit
    typedef struct packed {
        logic tx_eop_a;
        logic tx_eop_b;
        logic rx_eop_ack;
        logic tx_parity;
        logic read_n;
        logic write_n;
        logic empty_n;
        logic full_n;
    } spfm_queue_in_s;

endpackage : spfm_pkg

/* File: bench/spfm_far_side.sv */
// far side of the pads: memory, converter, queue and uart peripherals.
// assumes the device wins wherever its enable is high; idle lines pull up.
`timescale 1ns/1ps
`default_nettype none

module spfm_far_side (
    input wire logic [27:0] bus_out,
    input wire logic [27:0] bus_oe,
    input wire logic [27:0] far_bus,
    input wire logic [27:0] far_en,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] far_pin,
    input wire logic [7:0] far_pin_en,
    output logic [27:0] bus_lvl,
    output logic [7:0] pin_lvl
);
    // resolved level: device drive, else peripheral, else pull-up
    always_comb begin
        bus_lvl = (bus_oe & bus_out) | (~bus_oe & far_en & far_bus)
                | (~bus_oe & ~far_en);
        pin_lvl = (pin_oe & pin_out) | (~pin_oe & far_pin_en & far_pin)
                | (~pin_oe & ~far_pin_en);
    end
endmodule : spfm_far_side

`default_nettype wire

/* File: bench/tb_shared_pin_function_mux.sv */
// bench for the shared pin function mux: mode routing, pin alternates, timer.
// assumes inputs change 1 ns after the rising edge of a 40 ns clock.
`timescale 1ns/1ps
`default_nettype none

module tb_shared_pin_function_mux;
    import spfm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic reg_we = 1'b0;
    logic [27:0] bus_in, bus_out, bus_oe, far_bus = '0, far_en = '0;
    logic [7:0] gpio_in, gpio_out, gpio_oe, far_pin = '0, far_pin_en = '0;
    spfm_mem_out_s mem_o = '1;
    spfm_mem_in_s mem_i;
    spfm_conv_out_s conv_o = '0;
    spfm_queue_out_s queue_o = '0;
    spfm_queue_in_s queue_i;
    logic ua_rts_n = 1'b1, ub_tx = 1'b1, ub_rts_n = 1'b1;
    logic ua_cts_n, irq0_n, irq1_n, ub_rx, ub_cts_n, trig, tmr_exp;
    logic [31:0] tcount = '0, tperiod = 32'h00000005;
    logic [27:0] pu;
    logic [7:0] gpu;
    logic [1:0] lpd, jpd;
    int num_errors = 0, num_checks = 0;

    spfm_pin_mux dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .shared_control_bus_in(bus_in), .shared_control_bus_out(bus_out),
        .shared_control_bus_oe(bus_oe), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .mem_o(mem_o), .mem_i(mem_i),
        .conv_o(conv_o), .converter_trigger(trig), .queue_o(queue_o),
        .queue_i(queue_i), .uart_a_request_to_send_n(ua_rts_n),
        .uart_a_clear_to_send_n(ua_cts_n), .external_irq0_n(irq0_n),
        .external_irq1_n(irq1_n), .uart_b_tx(ub_tx), .uart_b_rx(ub_rx),
        .uart_b_request_to_send_n(ub_rts_n), .uart_b_clear_to_send_n(ub_cts_n),
        .timer_b_count(tcount), .timer_b_period(tperiod),
        .timer_b_expired(tmr_exp), .bus_pull_up(pu), .gpio_pull_up(gpu),
        .link_pull_down(lpd), .jtag_pull_down(jpd));

    spfm_far_side far_u (.bus_out(bus_out), .bus_oe(bus_oe), .far_bus(far_bus),
        .far_en(far_en), .pin_out(gpio_out), .pin_oe(gpio_oe),
        .far_pin(far_pin), .far_pin_en(far_pin_en), .bus_lvl(bus_in),
        .pin_lvl(gpio_in));

    // clock, 40 ns period
    initial begin
        forever #20 mclk = ~mclk;
    end

    // counts and verdict, single exit
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // compare one observed value
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_addr = a;
        reg_we = 1'b1;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_we = 1'b0;
    endtask : wr

    // registered read, data one cycle after address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        reg_addr = a;
        @(posedge mclk) #1;
        d = reg_rdata;
    endtask : rd

    // config reaches pins one cycle after the write edge
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    // reset values, pulls and unmapped read
    task automatic t_reset;
        rd(8'h01, rv); chk("iface_cfg", 8'h00, rv);
        rd(8'h59, rv); chk("uart_a_ctrl", 8'h00, rv);
        rd(8'h72, rv); chk("uart_b_ctrl", 8'h00, rv);
        rd(8'h40, rv); chk("unmapped", 8'h00, rv);
        chk("bus_oe", '0, bus_oe);
        chk("pulls", 32'hffff000f,
            {pu[27:20], gpu, 12'h000, lpd, jpd});
        chk("bus_pull", 28'hfffffff, pu);
    endtask : t_reset

    // ram mode lines
    task automatic t_ram;
        mem_o = '{16'hc35a, 1'b0, 1'b1, 4'b1011, 1'b1, 1'b0, 1'b1};
        far_en = 28'he000000;
        far_bus = 28'ha000000;
        wr(8'h01, 8'h01);
        settle;
        chk("ram_out", {7'h0, 1'b1, 1'b0, 1'b1, 4'b1011, 1'b1, 1'b0,
            16'hc35a}, bus_out[24:0]);
        chk("ram_oe", 28'h1ffffff, bus_oe);
        chk("mem_i", 3'b101, mem_i);
    endtask : t_ram

    // converter and active queue mode
    task automatic t_conv;
        conv_o = '{8'h3c, 1'b0, 1'b1, 1'b0, 3'b110};
        queue_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        far_en = 28'hfb00000;
        far_bus = 28'hda00000;
        wr(8'h01, 8'h02);
        settle;
        chk("conv_out", {2'b10, 2'b11, 2'b01, 3'b110, 3'b010, 8'h3c},
            bus_out[19:0]);
        chk("conv_oe", 28'h00fffff, bus_oe);
        chk("trigger", 1'b1, trig);
        chk("queue_i", 8'hbd, queue_i);
    endtask : t_conv

    // passive queue mode drops converter lines
    task automatic t_pass;
        far_en = 28'hf8c0000;
        far_bus = 28'hd880000;
        wr(8'h01, 8'h03);
        settle;
        chk("pass_oe", 28'h033c000, bus_oe);
        chk("pass_flags", 2'b10, bus_out[21:20]);
        chk("pass_rw", 2'b01, {queue_i.read_n, queue_i.write_n});
        chk("pass_trig", 1'b0, trig);
    endtask : t_pass

    // aux port on lines 7..0 in gpio mode
    task automatic t_aux;
        wr(8'h01, 8'h00);
        wr(8'h66, 8'hff);
        wr(8'h65, 8'ha5);
        settle;
        chk("aux_out", 16'hffa5, {bus_oe[7:0], bus_out[7:0]});
    endtask : t_aux

    // general pins: port then each alternate
    task automatic t_gpio;
        far_pin_en = 8'hae;
        far_pin = 8'h04;
        ua_rts_n = 1'b0;
        ub_tx = 1'b0;
        ub_rts_n = 1'b0;
        wr(8'h64, 8'hff);
        wr(8'h63, 8'h5a);
        settle;
        chk("port_a", 16'hff5a, {gpio_oe, gpio_out});
        chk("cts_a_idle", 1'b1, ua_cts_n);
        wr(8'h59, 8'h80);
        settle;
        chk("uart_a", 2'b00, {ua_cts_n, gpio_out[0]});
        wr(8'h01, 8'h40);
        settle;
        chk("irq", 2'b10, {irq0_n, irq1_n});
        wr(8'h01, 8'hc0);
        settle;
        chk("uart_b", 2'b00, {ub_rx, gpio_out[4]});
        wr(8'h72, 8'h80);
        settle;
        chk("uart_b_hs", 2'b00, {ub_cts_n, gpio_out[6]});
        chk("alt_oe", 8'h51, gpio_oe);
    endtask : t_gpio

    // held match pulses once, new match after a gap pulses again
    task automatic t_timer;
        int n;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk) #1;
            if (tmr_exp === 1'b1) n++;
            tcount = (i < 4 || i == 6) ? 32'h00000005 : 32'h00000002;
        end
        chk("pulses", 2, n);
    endtask : t_timer

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        t_reset;
        t_ram;
        t_conv;
        t_pass;
        t_aux;
        t_gpio;
        t_timer;
        wrap_up;
    end

    // hang guard
    initial begin
        #200000;
        num_errors++;
        wrap_up;
    end
endmodule : tb_shared_pin_function_mux

`default_nettype wire
